// >>> inc/ccd_serial_pkg.sv
// constants, types and reset values for the caption decoder serial control port
package ccd_serial_pkg;

  // two-wire slave addresses (7-bit forms of 28h/29h and 2Ah/2Bh)
  localparam logic [6:0] ADDR_FIRST = 7'h14;
  localparam logic [6:0] ADDR_SECOND = 7'h15;

  // command bytes; bit 7 set marks a command that carries one data byte
  localparam int CMD_TWO_BYTE_BIT = 7;
  localparam logic [7:0] CMD_IRQ_CLEAR = 8'h01;
  localparam logic [7:0] CMD_READ_ONE = 8'h02;
  localparam logic [7:0] CMD_READ_TWO = 8'h03;
  localparam logic [7:0] CMD_MODE = 8'h81;
  localparam logic [7:0] CMD_CFG_A = 8'h82;
  localparam logic [7:0] CMD_CFG_B = 8'h83;
  localparam logic [7:0] CMD_ROWS = 8'h84;
  localparam logic [7:0] CMD_IRQ_MASK = 8'h85;

  // three-wire resync string: this byte repeated SYNC_COUNT times
  localparam logic [7:0] SYNC_BYTE = 8'hFF;
  localparam logic [1:0] SYNC_COUNT = 2'h2;

  // status byte layout
  localparam int ST_READY = 7;
  localparam int ST_DAV = 6;
  localparam int ST_RD2 = 5;
  localparam int ST_IRQ = 4;

  // field positions of the data bytes of CMD_CFG_A and CMD_CFG_B
  localparam int CA_DECODER = 0;
  localparam int CA_LINES15 = 1;
  localparam int CA_BOX = 2;
  localparam int CA_EXTATTR = 3;
  localparam int CA_DATAOUT = 4;
  localparam int CA_PAL = 5;
  localparam int CA_COLOR = 6;
  localparam int CB_VLOCK_EXT = 0;
  localparam int CB_HLOCK_EXT = 1;
  localparam int CB_IRQ_EN = 2;
  localparam int CB_BLOCKING = 3;

  // eleven display modes
  typedef enum logic [3:0] {
    CAPTION_CHANNEL_ONE, CAPTION_CHANNEL_TWO, CAPTION_CHANNEL_THREE, CAPTION_CHANNEL_FOUR,
    TEXT_CHANNEL_ONE, TEXT_CHANNEL_TWO, TEXT_CHANNEL_THREE, TEXT_CHANNEL_FOUR,
    EXTENDED_DATA_FULL_TEMPLATE, EXTENDED_DATA_GRAZE_TEMPLATE, USER_SCREEN_OVERLAY
  } display_mode_t;
  localparam logic [3:0] MODE_COUNT = 4'hB;

  // operating configuration seen by the rest of the decoder
  typedef struct packed {
    display_mode_t displayMode;
    logic decoderOn;
    logic [3:0] textRows;
    logic [3:0] linesPerRow;
    logic boxBackground;
    logic extAttributes;
    logic dataOutputs;
    logic pal;
    logic vlockExternal;
    logic hlockExternal;
    logic [7:0] boxTimingTenthUs;
    logic color;
    logic irqEnable;
    logic blockingFilter;
    logic [7:0] irqMask;
  } cfg_t;

  localparam logic [3:0] ROWS_RESET = 4'hF;
  localparam logic [3:0] LINES_SHORT = 4'hD;
  localparam logic [3:0] LINES_LONG = 4'hF;
  localparam logic [7:0] BOX_TIMING_RESET = 8'h87; // 13.5 us in tenths
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam cfg_t CFG_RESET = '{CAPTION_CHANNEL_ONE, 1'b0, ROWS_RESET, LINES_SHORT, 1'b1,
    1'b1, 1'b0, 1'b0, 1'b0, 1'b0, BOX_TIMING_RESET, 1'b1, 1'b0, 1'b0, MASK_RESET};

  // decoder side inputs
  typedef struct packed {
    logic [7:0] events;
    logic ratingFound;
    logic xdsLoad;
    logic [15:0] readData;
  } dec_in_t;

  // asynchronous pins sampled into the system clock
  typedef struct packed {
    logic sck;
    logic sda;
    logic serial_mode_select;
    logic serial_port_enable;
    logic asel;
    logic vsync;
  } pins_t;

endpackage : ccd_serial_pkg

// >>> hdl/caption_serial_port.sv
// serial control port of a caption decoder: two-wire and three-wire slave
`timescale 1ns/1ps
// What this block does
// - mode-select pin high picks three-wire mode, low picks two-wire mode.
// - mode-select and enable both low hold the device in reset.
// - two-wire mode leaves data-out undriven; data line is bidirectional.
// - three-wire mode is slave only and moves whole 8-bit bytes.
// - three-wire mode: clock in, data line in, data-out pin out.
// - three-wire traffic only while enable high; data-out released while low.
// - rising enable restarts framing; next byte is a command.
// - with enable tied high, a sync byte string restarts framing.
// - two-wire mode is slave only; host makes clock, start and stop.
// - answers address pairs 29h/28h and 2Bh/2Ah, direction in bit 0.
// - address strap low picks first pair, high picks second pair.
// - own address after a start is acknowledged.
// - sync/interrupt pin is either vsync input or interrupt output.
// - video vertical lock makes that pin the interrupt output, both modes.
// - selected events raise the interrupt; a host write clears it.
// - blocking filter raises the interrupt only on the rating packet.
// - serial port is the only path for configuration and data readout.
// - eleven display modes: four caption, four text, two data, overlay.
// - reset restores the documented default configuration.
// - transmitter changes data on falling clock, msb first; receiver samples rising.
// - only bytes the command expects are acknowledged; extras are not.
// - every read starts with the status byte.
module caption_serial_port (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic sck,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic serialDataOut,
  output logic serialDataOutOe,
  input wire logic serialModeSelect,
  input wire logic serialPortEnable,
  input wire logic addrSelect,
  input wire logic vsyncInOrIrqOutIn,
  output logic vsyncInOrIrqOutOut,
  output logic vsyncInOrIrqOutOe,
  input wire ccd_serial_pkg::dec_in_t decIn,
  output ccd_serial_pkg::cfg_t cfg,
  output logic externalVsync,
  output logic deviceInReset
);
  import ccd_serial_pkg::*;

  typedef enum logic [2:0] {I2C_IDLE, I2C_ADDR, I2C_WR, I2C_RD} i2c_state_t;

  // system clock state
  typedef struct packed {
    pins_t p1;
    pins_t p2;
    pins_t p3;
    logic [2:0] tglSync;
    i2c_state_t i2cState;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic ackNext;
    logic isRead;
    logic curIsData;
    logic [1:0] rdLeft;
    logic [1:0] wrCount;
    logic sdaOe;
    logic expectData;
    logic [7:0] cmd;
    logic [1:0] syncCnt;
    logic dav;
    logic rd2;
    logic [15:0] outData;
    logic irq;
    logic [7:0] txHold;
    logic txTgl;
    cfg_t cfg;
    logic pinOut;
    logic pinOe;
    logic extVsync;
    logic inReset;
  } sys_t;

  // link clock state
  typedef struct packed {
    logic [2:0] bitCnt;
    logic [7:0] rxShift;
    logic [7:0] rxByte;
    logic rxTgl;
    logic ackS1;
    logic ackS2;
    logic [7:0] txShift;
    logic gotOne;
  } link_t;

  sys_t sys_r;
  sys_t sys_nxt;
  link_t link_r;
  link_t link_nxt;
  logic rstS1_r;
  logic rstN;
  logic linkRstN;
  logic sdo_r;
  logic sdoOe_r;

  // reset release through two flip-flops
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      rstS1_r <= 1'b0;
      rstN <= 1'b0;
    end
    else
    begin
      rstS1_r <= 1'b1;
      rstN <= rstS1_r;
    end
  end

  // system side: pin sampling, two-wire slave, command decode, interrupt
  always_comb
  begin
    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;
    logic gotByte;
    logic [7:0] rxb;
    logic [7:0] inByte;
    logic [7:0] status;
    logic irqEvent;
    sys_nxt = sys_r;
    gotByte = 1'b0;
    rxb = 8'h00;
    sys_nxt.p1 = '{sck, sdaIn, serialModeSelect, serialPortEnable, addrSelect,
      vsyncInOrIrqOutIn};
    sys_nxt.p2 = sys_r.p1;
    sys_nxt.p3 = sys_r.p2;
    sys_nxt.tglSync = {sys_r.tglSync[1:0], link_r.rxTgl};
    inByte = {sys_r.shift[6:0], sys_r.p2.sda};
    sclRise = sys_r.p2.sck & ~sys_r.p3.sck;
    sclFall = ~sys_r.p2.sck & sys_r.p3.sck;
    startCond = sys_r.p2.sck & sys_r.p3.sck & sys_r.p3.sda & ~sys_r.p2.sda;
    stopCond = sys_r.p2.sck & sys_r.p3.sck & ~sys_r.p3.sda & sys_r.p2.sda;
    status = 8'h00;
    status[ST_READY] = 1'b1;
    status[ST_DAV] = sys_r.dav;
    status[ST_RD2] = sys_r.rd2;
    status[ST_IRQ] = sys_r.irq;
    // two-wire slave, only while mode-select is low
    if (sys_r.p2.serial_mode_select)
    begin
      sys_nxt.i2cState = I2C_IDLE;
      sys_nxt.sdaOe = 1'b0;
    end
    else if (startCond)
    begin
      sys_nxt.i2cState = I2C_ADDR;
      sys_nxt.bitCnt = 4'h0;
      sys_nxt.sdaOe = 1'b0;
    end
    else if (stopCond)
    begin
      sys_nxt.i2cState = I2C_IDLE;
      sys_nxt.sdaOe = 1'b0;
    end
    else
    begin
      case (sys_r.i2cState)
        I2C_ADDR, I2C_WR:
        begin
          if (sclRise && sys_r.bitCnt < 4'h8)
          begin
            sys_nxt.shift = inByte;
            sys_nxt.bitCnt = sys_r.bitCnt + 4'h1;
            if (sys_r.bitCnt == 4'h7 && sys_r.i2cState == I2C_ADDR)
            begin
              sys_nxt.ackNext = (inByte[7:1] ==
                (sys_r.p2.asel ? ADDR_SECOND : ADDR_FIRST));
              sys_nxt.isRead = inByte[0];
              sys_nxt.wrCount = 2'h0;
              sys_nxt.rdLeft = sys_r.dav ? (sys_r.rd2 ? 2'h2 : 2'h1) : 2'h0;
            end
            else if (sys_r.bitCnt == 4'h7)
            begin
              sys_nxt.ackNext = (sys_r.wrCount != 2'h2);
              gotByte = (sys_r.wrCount != 2'h2);
              rxb = inByte;
              if (sys_r.wrCount == 2'h0 && inByte[CMD_TWO_BYTE_BIT])
                sys_nxt.wrCount = 2'h1;
              else
                sys_nxt.wrCount = 2'h2;
            end
          end
          else if (sclRise && sys_r.bitCnt == 4'h8)
            sys_nxt.bitCnt = 4'h9;
          else if (sclFall && sys_r.bitCnt == 4'h8)
          begin
            sys_nxt.sdaOe = sys_r.ackNext;
            if (sys_r.i2cState == I2C_ADDR && !sys_r.ackNext)
              sys_nxt.i2cState = I2C_IDLE;
          end
          else if (sclFall && sys_r.bitCnt == 4'h9)
          begin
            sys_nxt.bitCnt = 4'h0;
            sys_nxt.sdaOe = 1'b0;
            if (sys_r.i2cState == I2C_ADDR && sys_r.isRead)
            begin
              sys_nxt.i2cState = I2C_RD;
              sys_nxt.shift = status;
              sys_nxt.curIsData = 1'b0;
              sys_nxt.sdaOe = ~status[7];
            end
            else if (sys_r.i2cState == I2C_ADDR)
            begin
              sys_nxt.i2cState = I2C_WR;
              sys_nxt.expectData = 1'b0;
            end
          end
        end
        I2C_RD:
        begin
          if (sclRise && sys_r.bitCnt < 4'h8)
          begin
            sys_nxt.bitCnt = sys_r.bitCnt + 4'h1;
            if (sys_r.bitCnt == 4'h7 && sys_r.curIsData && sys_r.rdLeft == 2'h0)
              sys_nxt.dav = 1'b0; // last data bit clocked out
          end
          else if (sclRise && sys_r.bitCnt == 4'h8)
          begin
            sys_nxt.bitCnt = 4'h9;
            sys_nxt.ackNext = ~sys_r.p2.sda;
          end
          else if (sclFall && sys_r.bitCnt == 4'h8)
            sys_nxt.sdaOe = 1'b0;
          else if (sclFall && sys_r.bitCnt == 4'h9)
          begin
            sys_nxt.bitCnt = 4'h0;
            if (sys_r.ackNext && sys_r.rdLeft != 2'h0)
            begin
              sys_nxt.shift = (sys_r.rdLeft == 2'h2) ? sys_r.outData[15:8] : sys_r.outData[7:0];
              sys_nxt.sdaOe = (sys_r.rdLeft == 2'h2) ? ~sys_r.outData[15] : ~sys_r.outData[7];
              sys_nxt.rdLeft = sys_r.rdLeft - 2'h1;
              sys_nxt.curIsData = 1'b1;
            end
            else
              sys_nxt.i2cState = I2C_IDLE;
          end
          else if (sclFall && sys_r.bitCnt != 4'h0)
          begin
            sys_nxt.shift = {sys_r.shift[6:0], 1'b0};
            sys_nxt.sdaOe = ~sys_r.shift[6];
          end
        end
        default:
          sys_nxt.sdaOe = 1'b0;
      endcase
    end
    // three-wire byte arrival and framing
    if (sys_r.p2.serial_mode_select)
    begin
      if (sys_r.p2.serial_port_enable && !sys_r.p3.serial_port_enable)
        sys_nxt.expectData = 1'b0;
      else if (sys_r.p2.serial_port_enable && sys_r.tglSync[2] != sys_r.tglSync[1]) // link clear is no byte
      begin
        rxb = link_r.rxByte;
        sys_nxt.txHold = status;
        sys_nxt.txTgl = sys_r.tglSync[1];
        if (rxb == SYNC_BYTE)
          sys_nxt.syncCnt = (sys_r.syncCnt == SYNC_COUNT) ? SYNC_COUNT : sys_r.syncCnt + 2'h1;
        else
          sys_nxt.syncCnt = 2'h0;
        if (rxb == SYNC_BYTE && sys_r.syncCnt + 2'h1 == SYNC_COUNT)
          sys_nxt.expectData = 1'b0;
        else
          gotByte = 1'b1;
      end
    end
    // command execution, the only path to configuration; readout data also loads automatically
    if (gotByte && !sys_r.expectData && rxb[CMD_TWO_BYTE_BIT])
    begin
      sys_nxt.cmd = rxb;
      sys_nxt.expectData = 1'b1;
    end
    else if (gotByte && sys_r.expectData)
    begin
      sys_nxt.expectData = 1'b0;
      if (sys_r.cmd == CMD_MODE && rxb[3:0] < MODE_COUNT)
        sys_nxt.cfg.displayMode = display_mode_t'(rxb[3:0]);
      else if (sys_r.cmd == CMD_CFG_A)
      begin
        sys_nxt.cfg.decoderOn = rxb[CA_DECODER];
        sys_nxt.cfg.linesPerRow = rxb[CA_LINES15] ? LINES_LONG : LINES_SHORT;
        sys_nxt.cfg.boxBackground = rxb[CA_BOX];
        sys_nxt.cfg.extAttributes = rxb[CA_EXTATTR];
        sys_nxt.cfg.dataOutputs = rxb[CA_DATAOUT];
        sys_nxt.cfg.pal = rxb[CA_PAL];
        sys_nxt.cfg.color = rxb[CA_COLOR];
      end
      else if (sys_r.cmd == CMD_CFG_B)
      begin
        sys_nxt.cfg.vlockExternal = rxb[CB_VLOCK_EXT];
        sys_nxt.cfg.hlockExternal = rxb[CB_HLOCK_EXT];
        sys_nxt.cfg.irqEnable = rxb[CB_IRQ_EN];
        sys_nxt.cfg.blockingFilter = rxb[CB_BLOCKING];
      end
      else if (sys_r.cmd == CMD_ROWS)
        sys_nxt.cfg.textRows = rxb[3:0];
      else if (sys_r.cmd == CMD_IRQ_MASK)
        sys_nxt.cfg.irqMask = rxb;
    end
    else if (gotByte && (rxb == CMD_READ_ONE || rxb == CMD_READ_TWO))
    begin
      sys_nxt.outData = decIn.readData;
      sys_nxt.rd2 = (rxb == CMD_READ_TWO);
      sys_nxt.dav = 1'b1;
    end
    else if (gotByte && rxb == CMD_IRQ_CLEAR)
      sys_nxt.irq = 1'b0;
    // automatic load of recovered data pairs
    if (decIn.xdsLoad && !sys_r.dav)
    begin
      sys_nxt.outData = decIn.readData;
      sys_nxt.rd2 = 1'b1;
      sys_nxt.dav = 1'b1;
    end
    // interrupt: sticky, set wins over clear
    if (sys_r.cfg.blockingFilter)
      irqEvent = decIn.ratingFound;
    else
      irqEvent = |(decIn.events & sys_r.cfg.irqMask);
    if (irqEvent && sys_r.cfg.irqEnable)
      sys_nxt.irq = 1'b1;
    // dual-use pin
    sys_nxt.pinOe = ~sys_nxt.cfg.vlockExternal;
    sys_nxt.pinOut = sys_nxt.irq & sys_nxt.cfg.irqEnable;
    sys_nxt.extVsync = sys_r.p2.vsync & sys_r.cfg.vlockExternal;
    // pin reset: both pins low hold every setting at its default
    sys_nxt.inReset = ~sys_r.p2.serial_mode_select & ~sys_r.p2.serial_port_enable;
    if (sys_nxt.inReset)
    begin
      sys_nxt.i2cState = I2C_IDLE;
      sys_nxt.sdaOe = 1'b0;
      sys_nxt.expectData = 1'b0;
      sys_nxt.syncCnt = 2'h0;
      sys_nxt.dav = 1'b0;
      sys_nxt.rd2 = 1'b0;
      sys_nxt.irq = 1'b0;
      sys_nxt.cfg = CFG_RESET;
      sys_nxt.pinOe = 1'b1;
      sys_nxt.pinOut = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstN)
  begin
    if (!rstN)
    begin
      sys_r <= '0;
      sys_r.i2cState <= I2C_IDLE;
      sys_r.cfg <= CFG_RESET;
      sys_r.pinOe <= 1'b1;
      sys_r.inReset <= 1'b1;
    end
    else
      sys_r <= sys_nxt;
  end

  // link side clears while enable is low or in two-wire mode
  assign linkRstN = rstN & serialPortEnable & serialModeSelect;

  // link side: shift in on rising clock, hand bytes over by toggle
  always_comb
  begin
    link_nxt = link_r;
    link_nxt.ackS1 = sys_r.txTgl;
    link_nxt.ackS2 = link_r.ackS1;
    link_nxt.rxShift = {link_r.rxShift[6:0], sdaIn};
    link_nxt.bitCnt = link_r.bitCnt + 3'h1;
    link_nxt.txShift = {link_r.txShift[6:0], 1'b1};
    if (link_r.bitCnt == 3'h7)
    begin
      link_nxt.rxByte = {link_r.rxShift[6:0], sdaIn};
      link_nxt.rxTgl = ~link_r.rxTgl;
      // reply FF after a link clear or until the system side has answered the last byte
      link_nxt.gotOne = 1'b1;
      link_nxt.txShift = (link_r.gotOne && link_r.ackS2 == link_r.rxTgl) ? sys_r.txHold : 8'hFF;
    end
  end

  always_ff @(posedge sck or negedge linkRstN)
  begin
    if (!linkRstN)
      link_r <= '0;
    else
      link_r <= link_nxt;
  end

  // data-out changes on the falling clock, released while enable is low
  always_ff @(negedge sck or negedge linkRstN)
  begin
    if (!linkRstN)
    begin
      sdo_r <= 1'b0;
      sdoOe_r <= 1'b0;
    end
    else
    begin
      sdo_r <= link_r.txShift[7];
      sdoOe_r <= 1'b1;
    end
  end

  // outputs
  assign sdaOut = 1'b0; // open drain: only ever pulls low
  assign sdaOe = sys_r.sdaOe;
  assign serialDataOut = sdo_r;
  assign serialDataOutOe = sdoOe_r;
  assign vsyncInOrIrqOutOut = sys_r.pinOut;
  assign vsyncInOrIrqOutOe = sys_r.pinOe;
  assign cfg = sys_r.cfg;
  assign externalVsync = sys_r.extVsync;
  assign deviceInReset = sys_r.inReset;

endmodule : caption_serial_port

// >>> testbench/caption_serial_port_monitor.sv
// assertion checker for the caption serial port pins
`timescale 1ns/1ps
module caption_serial_port_monitor (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic sck,
  input wire logic sdaOe,
  input wire logic serialDataOutOe,
  input wire logic serialModeSelect,
  input wire logic serialPortEnable,
  input wire logic vsyncInOrIrqOutOut,
  input wire logic vsyncInOrIrqOutOe,
  input wire ccd_serial_pkg::cfg_t cfg,
  input wire logic externalVsync,
  input wire logic deviceInReset
);
  import ccd_serial_pkg::*;
  logic [3:0] upCnt_r;
  logic [3:0] quietCnt_r;
  logic sckOld_r;
  // cycles since reset release and since the last serial clock change
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      upCnt_r <= 4'h0;
      quietCnt_r <= 4'h0;
      sckOld_r <= 1'b1;
    end
    else
    begin
      sckOld_r <= sck;
      upCnt_r <= (upCnt_r == 4'hF) ? upCnt_r : upCnt_r + 4'h1;
      quietCnt_r <= (sck != sckOld_r) ? 4'h0 : (quietCnt_r == 4'hF) ? 4'hF : quietCnt_r + 4'h1;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  property p_sdo_i2c; (!serialModeSelect)[*4] |-> !serialDataOutOe; endproperty
  property p_sdo_dis; (!serialPortEnable)[*4] |-> !serialDataOutOe; endproperty
  property p_sda_spi; serialModeSelect[*4] |-> !sdaOe; endproperty
  property p_pin_rst; (!serialModeSelect && !serialPortEnable)[*4] |-> deviceInReset; endproperty
  property p_run; (upCnt_r == 4'hF && serialPortEnable)[*5] |-> !deviceInReset; endproperty
  property p_defaults; deviceInReset && $past(deviceInReset) |-> cfg == CFG_RESET; endproperty
  property p_irq_hold;
    quietCnt_r == 4'hF && $past(vsyncInOrIrqOutOut) && $past(cfg.irqEnable) && cfg.irqEnable
      && !deviceInReset |-> vsyncInOrIrqOutOut;
  endproperty
  property p_pin_dir;
    $stable(cfg.vlockExternal)[*3] |-> vsyncInOrIrqOutOe == !cfg.vlockExternal;
  endproperty
  property p_irq_gate; (!cfg.irqEnable)[*2] |-> !vsyncInOrIrqOutOut; endproperty
  property p_ext_vs; (!cfg.vlockExternal)[*2] |-> !externalVsync; endproperty
  a_sdo_i2c: assert property (p_sdo_i2c) else $error("data out driven in two-wire mode");
  a_sdo_dis: assert property (p_sdo_dis) else $error("data out driven while disabled");
  a_sda_spi: assert property (p_sda_spi) else $error("data line driven in three-wire");
  a_pin_rst: assert property (p_pin_rst) else $error("pin reset not entered");
  a_run: assert property (p_run) else $error("reset held with enable high");
  a_defaults: assert property (p_defaults) else $error("configuration not at defaults");
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped while bus idle");
  a_pin_dir: assert property (p_pin_dir) else $error("sync pin direction wrong");
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt while disabled");
  a_ext_vs: assert property (p_ext_vs) else $error("external sync used on video lock");
  c_ack: cover property (sdaOe);
  c_irq: cover property (vsyncInOrIrqOutOut);
  c_pin_rst: cover property (deviceInReset && upCnt_r == 4'hF);
endmodule : caption_serial_port_monitor
bind caption_serial_port caption_serial_port_monitor caption_serial_port_monitor_i (.clk_sys,
  .nrst, .sck, .sdaOe, .serialDataOutOe, .serialModeSelect, .serialPortEnable,
  .vsyncInOrIrqOutOut, .vsyncInOrIrqOutOe, .cfg, .externalVsync, .deviceInReset);

// >>> testbench/host_master_model.sv
// host master model for both serial control modes
`timescale 1ns/1ps
module host_master_model (
  output logic sck,
  output logic sdaLow,
  output logic mosi,
  input wire logic sdaLine,
  input wire logic sdoLine
);
  localparam int H = 200;
  localparam int Q = 100;
  localparam int L = 80;
  // bus idle: clock and data high
  initial
  begin
    sck = 1'b1;
    sdaLow = 1'b0;
    mosi = 1'b1;
  end
  // start or repeated start: data falls while clock high
  task automatic i2cStart();
    #3;
    if (!sck)
    begin
      sdaLow = 1'b0;
      #Q sck = 1'b1;
      #H;
    end
    sdaLow = 1'b1;
    #H sck = 1'b0;
  endtask : i2cStart
  // stop: data rises while clock high
  task automatic i2cStop();
    #Q sdaLow = 1'b1;
    #Q sck = 1'b1;
    #H sdaLow = 1'b0;
    #H;
  endtask : i2cStop
  // eight bits plus the acknowledge clock; mAck pulls the ninth bit low
  task automatic i2cByte(input logic [7:0] tx, input logic mAck, output logic [7:0] rx,
    output logic ack);
    for (int i = 8; i >= 0; i--)
    begin
      #Q sdaLow = (i > 0) ? !tx[i-1] : mAck;
      #Q sck = 1'b1;
      if (i > 0)
        rx[i-1] = sdaLine;
      else
        ack = !sdaLine;
      #H sck = 1'b0;
    end
  endtask : i2cByte
  // one three-wire byte, clock idles high between frames
  task automatic spiByte(input logic [7:0] tx, output logic [7:0] rx);
    #7;
    for (int i = 7; i >= 0; i--)
    begin
      sck = 1'b0;
      mosi = tx[i];
      #L sck = 1'b1;
      rx[i] = sdoLine;
      #L;
    end
    mosi = ~mosi;
  endtask : spiByte
endmodule : host_master_model

// >>> testbench/caption_serial_port_test.sv
// self-checking bench for the caption serial port
`timescale 1ns/1ps
module caption_serial_port_test;
  import ccd_serial_pkg::*;
  logic clk_sys, nrst, serial_mode_select, serial_port_enable, asel, vsIn, sdaOe, sdaOut, serial_data_out, sdoOe;
  logic irqOut, irqOe, extVs, inRst, sck, sdaLow, mosi, sdaLine, sdoLine, ack;
  logic [7:0] rx, b, d;
  logic [3:0] mode;
  dec_in_t decIn;
  cfg_t cfg;
  int n_errors, cmp_count, cycles;
  // open-drain data line with pull-up; data out floats to its inverse
  assign sdaLine = !(sdaLow || sdaOe);
  assign sdoLine = sdoOe ? serial_data_out : ~serial_data_out;
  caption_serial_port caption_serial_port_i (.clk_sys, .nrst, .sck,
    .sdaIn(serial_mode_select ? mosi : sdaLine), .sdaOut, .sdaOe, .serialDataOut(serial_data_out),
    .serialDataOutOe(sdoOe), .serialModeSelect(serial_mode_select), .serialPortEnable(serial_port_enable),
    .addrSelect(asel), .vsyncInOrIrqOutIn(vsIn), .vsyncInOrIrqOutOut(irqOut),
    .vsyncInOrIrqOutOe(irqOe), .decIn, .cfg, .externalVsync(extVs), .deviceInReset(inRst));
  host_master_model host_master_model_i (.sck, .sdaLow, .mosi, .sdaLine, .sdoLine);
  // system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // cycle ceiling against hangs
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 90000)
    begin
      n_errors++;
      close_out();
    end
  end
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // either address byte of the strapped pair, read or write
  function automatic logic expAck(input logic a, input logic [7:0] addr);
    return {addr[7:1], 1'b0} == (a ? 8'h2A : 8'h28);
  endfunction : expAck
  task automatic wr(input logic [7:0] cmd, input logic [7:0] dat);
    host_master_model_i.i2cStart();
    host_master_model_i.i2cByte(asel ? 8'h2A : 8'h28, 1'b0, rx, ack);
    check("addr ack", ack, 1'b1);
    host_master_model_i.i2cByte(cmd, 1'b0, rx, ack);
    check("cmd ack", ack, 1'b1);
    host_master_model_i.i2cByte(dat, 1'b0, rx, ack);
    check("data ack", ack, cmd[CMD_TWO_BYTE_BIT]);
    host_master_model_i.i2cByte(8'h55, 1'b0, rx, ack);
    check("extra ack", ack, 1'b0);
    host_master_model_i.i2cStop();
  endtask : wr
  task automatic rdStatus();
    host_master_model_i.i2cStart();
    host_master_model_i.i2cByte(asel ? 8'h2B : 8'h29, 1'b0, rx, ack);
    check("rd ack", ack, 1'b1);
    host_master_model_i.i2cByte(8'hFF, 1'b0, rx, ack);
    host_master_model_i.i2cStop();
    check("ready", rx[ST_READY], 1'b1);
  endtask : rdStatus
  task automatic pins(input logic m, input logic e, input int n);
    @(posedge clk_sys);
    serial_mode_select <= m;
    serial_port_enable <= e;
    repeat (n) @(posedge clk_sys);
  endtask : pins
  task automatic pulse(input logic [7:0] ev, input logic rate);
    @(posedge clk_sys);
    decIn.events <= ev;
    decIn.ratingFound <= rate;
    @(posedge clk_sys);
    decIn.events <= 8'h00;
    decIn.ratingFound <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask : pulse
  // main sequence
  initial
  begin
    void'($urandom(32'h910aea6f));
    {nrst, serial_mode_select, serial_port_enable, asel, vsIn} = 5'h04;
    decIn = '0;
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (8) @(posedge clk_sys);
    check("reset cfg", cfg, CFG_RESET);
    check("in reset", inRst, 1'b0);
    check("sdo oe", sdoOe, 1'b0);
    check("pin oe", irqOe, 1'b1);
    for (int a = 0; a < 2; a++)
    begin
      @(posedge clk_sys) asel <= a[0];
      repeat (4) @(posedge clk_sys);
      for (int k = 0; k < 4; k++)
      begin
        b = (k == 3) ? 8'($urandom) : 8'h28 + 8'(k);
        host_master_model_i.i2cStart();
        host_master_model_i.i2cByte(b, 1'b0, rx, ack);
        check("addr", ack, expAck(a[0], b));
        host_master_model_i.i2cByte(b[0] ? 8'hFF : CMD_IRQ_CLEAR, 1'b0, rx, ack);
        host_master_model_i.i2cStop();
      end
    end
    mode = 4'h0;
    for (int m = 0; m < 12; m++)
    begin
      d = (m < 11) ? 8'(m) : 8'(11 + $urandom % 245);
      wr(CMD_MODE, d);
      mode = (d[3:0] < MODE_COUNT) ? d[3:0] : mode;
      check("mode", cfg.displayMode, mode);
    end
    rdStatus();
    // two-byte readout after a read command: status, high byte, low byte
    @(posedge clk_sys) decIn.readData <= 16'($urandom);
    wr(CMD_READ_TWO, 8'h00);
    host_master_model_i.i2cStart();
    host_master_model_i.i2cByte(asel ? 8'h2B : 8'h29, 1'b0, rx, ack);
    host_master_model_i.i2cByte(8'hFF, 1'b1, rx, ack);
    check("st dav", rx[ST_DAV:ST_RD2], 2'h3);
    host_master_model_i.i2cByte(8'hFF, 1'b1, rx, ack);
    check("rd hi", rx, decIn.readData[15:8]);
    host_master_model_i.i2cByte(8'hFF, 1'b0, rx, ack);
    check("rd lo", rx, decIn.readData[7:0]);
    host_master_model_i.i2cStop();
    wr(CMD_IRQ_MASK, 8'h01);
    wr(CMD_CFG_B, 8'(1 << CB_IRQ_EN));
    check("irq idle", irqOut, 1'b0);
    pulse(8'h01, 1'b0);
    check("irq set", irqOut, 1'b1);
    rdStatus();
    check("irq kept", irqOut, 1'b1);
    check("st irq", rx[ST_IRQ], 1'b1);
    check("dav clr", rx[ST_DAV], 1'b0);
    wr(CMD_IRQ_CLEAR, 8'h00);
    check("irq clr", irqOut, 1'b0);
    pulse(8'h02, 1'b0);
    check("irq masked", irqOut, 1'b0);
    wr(CMD_CFG_B, 8'(1 << CB_IRQ_EN | 1 << CB_BLOCKING));
    pulse(8'h01, 1'b0);
    check("blk event", irqOut, 1'b0);
    pulse(8'h00, 1'b1);
    check("blk rating", irqOut, 1'b1);
    wr(CMD_CFG_B, 8'(1 << CB_VLOCK_EXT));
    check("pin in", irqOe, 1'b0);
    @(posedge clk_sys) vsIn <= 1'b1;
    repeat (6) @(posedge clk_sys);
    check("ext vsync", extVs, 1'b1);
    pins(1'b0, 1'b0, 6);
    check("pin reset", inRst, 1'b1);
    check("reset cfg", cfg, CFG_RESET);
    pins(1'b1, 1'b0, 6);
    check("sdo off", sdoOe, 1'b0);
    check("out of reset", inRst, 1'b0);
    for (int s = 0; s < 3; s++)
    begin
      d = 8'($urandom % 11);
      pins(1'b1, 1'b1, 4);
      if (s == 1)
      begin
        host_master_model_i.spiByte(CMD_MODE, rx);
        pins(1'b1, 1'b0, 4);
        pins(1'b1, 1'b1, 4);
      end
      if (s == 2)
      begin
        host_master_model_i.spiByte(CMD_MODE, rx);
        for (int j = 0; j < int'(SYNC_COUNT); j++)
          host_master_model_i.spiByte(SYNC_BYTE, rx);
      end
      host_master_model_i.spiByte(CMD_MODE, rx);
      host_master_model_i.spiByte(d, rx);
      repeat (10) @(posedge clk_sys);
      check("spi mode", cfg.displayMode, d[3:0]);
      check("spi sdo oe", sdoOe, 1'b1);
      check("spi status", rx[ST_READY], 1'b1);
    end
    close_out();
  end
endmodule : caption_serial_port_test
